/* bench/flash_interface_boot_config_reg_bench.sv */
// self-checking bench for the interface configuration registers
// assumes the host model owns the link; expected values kept in queues
`timescale 1ns/1ps
module flash_interface_boot_config_reg_bench;
   import flash_cfg_pkg::*;
   // short program time so status polling sees busy within one read
   localparam int unsigned PROG = 400;
   logic        ref_clk;
   logic        rst;
   logic        quad_data_enable;
   logic        sw_reset_req;
   logic        spi_clk;
   logic        cs_n;
   logic [3:0]  io_in;
   logic [3:0]  io_out;
   logic [3:0]  io_oe_n;
   iface_cfg_s  live_cfg;
   logic        quad_width_active;
   logic        nv_busy;
   int          fails;
   int          compares;
   logic [15:0] lfsr;
   bit          hq;
   bit          ha4;
   logic [7:0]  v;
   logic [7:0]  rq[$];
   logic [12:0] cq[$];
   logic [7:0]  seen_rd;
   logic [12:0] seen_cfg;
   event        ev_rd;
   event        ev_cfg;
   logic [7:0]  cmds [4];
   logic [7:0]  exps [4];

   ////////////////////////////////////////////////////////////////////////
   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   iface_config_core #(.PROGRAM_CYCLES(PROG)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n),
      .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
      .quad_data_enable(quad_data_enable), .sw_reset_req(sw_reset_req),
      .live_cfg(live_cfg), .quad_width_active(quad_width_active),
      .nv_busy(nv_busy));

   spi_host_model i_host (
      .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] next_rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction

   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[ERR] register read exp %h got %h", e, g);
      end
   endtask

   task automatic cmp_cfg(input logic [12:0] e, input logic [12:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[ERR] io_oe_n quad_width_active live_cfg exp %h got %h",
                  e, g);
      end
   endtask

   always @(ev_rd) cmp_reg(rq.pop_front(), seen_rd);
   always @(ev_cfg) cmp_cfg(cq.pop_front(), seen_cfg);

   task automatic frame(input logic [7:0] c, input logic [31:0] a,
                        input bit has_a, input bit has_d,
                        input logic [7:0] d, output logic [7:0] rd);
      logic [7:0] tx[$];
      tx = {c};
      if (has_a && ha4) tx.push_back(a[31:24]);
      if (has_a) tx.push_back(a[23:16]);
      if (has_a) tx.push_back(a[15:8]);
      if (has_a) tx.push_back(a[7:0]);
      if (has_d) tx.push_back(d);
      i_host.xfer(tx, hq, (has_a && !has_d) ? 1 : 0, rd);
   endtask

   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      frame(c, 32'h0000_0000, 1'b0, 1'b0, 8'h00, r);
   endtask

   task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
      logic [7:0] r;
      frame(WRITE_ANY_REGISTER_CMD, a, 1'b1, 1'b1, d, r);
   endtask

   task automatic rd_reg(input logic [31:0] a, input logic [7:0] e);
      logic [7:0] r;
      rq.push_back(e);
      frame(READ_ANY_REGISTER_CMD, a, 1'b1, 1'b0, 8'h00, r);
      seen_rd = r;
      -> ev_rd;
   endtask

   // switch completes well inside the fixed wait after the frame
   task automatic chk_cfg(input logic [7:0] e);
      // between frames every pin is released, so all enables idle high
      cq.push_back({4'hF, e[3] | quad_data_enable, e});
      repeat (8) @(negedge ref_clk);
      seen_cfg = {io_oe_n, quad_width_active, live_cfg};
      -> ev_cfg;
   endtask

   task automatic end_sim();
      if (fails == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #300000;
      fails++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      sw_reset_req = 1'b0;
      quad_data_enable = 1'b0;
      lfsr = 16'hCE1E;
      hq = 1'b0;
      ha4 = 1'b0;
      fails = 0;
      compares = 0;
      cmds = '{QUAD_INSTRUCTION_ENTER_CMD, QUAD_INSTRUCTION_EXIT_CMD,
               ADDR_FOUR_ENTER_CMD, ADDR_FOUR_EXIT_CMD};
      exps = '{8'h68, 8'h60, 8'h61, 8'h60};
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      chk_cfg(8'h60);
      rd_reg(ADDR_BOOT_CFG, 8'h60);
      rd_reg(ADDR_LIVE_CFG, 8'h60);
      // every drive code, other bits random; host follows its own writes
      for (int i = 0; i < 4; i++) begin
         v = next_rnd();
         v[6:5] = i[1:0];
         wr_reg(ADDR_LIVE_CFG, v);
         hq = v[3];
         ha4 = v[0];
         chk_cfg(v & LIVE_WR_MASK);
         rd_reg(ADDR_LIVE_CFG, v & LIVE_WR_MASK);
      end
      wr_reg(ADDR_LIVE_CFG, 8'h60);
      hq = 1'b0;
      ha4 = 1'b0;
      chk_cfg(8'h60);
      // mode commands, each followed by a read in the new protocol
      for (int i = 0; i < 4; i++) begin
         cmd(cmds[i]);
         hq = exps[i][3];
         ha4 = exps[i][0];
         chk_cfg(exps[i]);
         rd_reg(ADDR_LIVE_CFG, exps[i]);
      end
      @(negedge ref_clk) quad_data_enable = 1'b1;
      chk_cfg(8'h60);
      @(negedge ref_clk) quad_data_enable = 1'b0;
      // boot copy guarded by the write enable
      wr_reg(ADDR_BOOT_CFG, 8'hFF);
      rd_reg(ADDR_BOOT_CFG, 8'h60);
      cmd(NONVOLATILE_WRITE_ENABLE_CMD);
      rd_reg(ADDR_STATUS_ONE, 8'h02);
      wr_reg(ADDR_BOOT_CFG, 8'hFF);
      rd_reg(ADDR_STATUS_ONE, 8'h03);
      for (int n = 0; n < 2000 && nv_busy !== 1'b0; n++) @(negedge ref_clk);
      // boot bit 1 is now set, so the live length is four bytes already
      ha4 = 1'b1;
      rd_reg(ADDR_STATUS_ONE, 8'h00);
      chk_cfg(8'h63);
      rd_reg(ADDR_BOOT_CFG, 8'hEE);
      // software reset then io3 reset both load the boot copy
      @(negedge ref_clk) sw_reset_req = 1'b1;
      @(negedge ref_clk) sw_reset_req = 1'b0;
      hq = 1'b1;
      chk_cfg(8'hEF);
      rd_reg(ADDR_LIVE_CFG, 8'hEF);
      wr_reg(ADDR_LIVE_CFG, 8'h80);
      hq = 1'b0;
      ha4 = 1'b0;
      chk_cfg(8'h82);
      i_host.pulse_rst();
      hq = 1'b1;
      ha4 = 1'b1;
      chk_cfg(8'hEF);
      // io3 low while deselected with the io3 reset enable clear must not reset
      wr_reg(ADDR_LIVE_CFG, 8'h6D);
      chk_cfg(8'h6F);
      i_host.pulse_rst();
      chk_cfg(8'h6F);
      end_sim();
   end
endmodule

/* bench/spi_host_model.sv */
// host side of the serial link: drives whole frames, samples read data
// assumes mode 0 timing, io3 pulled up, device samples on rising spi_clk
`timescale 1ns/1ps
module spi_host_model (
   output logic            spi_clk,
   output logic            cs_n,
   output logic [3:0]      io_in,
   input  wire logic [3:0] io_out
);
   logic       io3_rst_n;
   logic [3:0] last;

   ////////////////////////////////////////////////////////////////////////
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      io3_rst_n = 1'b1;
      last = 4'h0;
      io_in = 4'h8;
   end

   // released lines show the inverse of the last level, not a stale copy
   task automatic idle();
      io_in = {io3_rst_n, ~last[2:0]};
   endtask

   ////////////////////////////////////////////////////////////////////////
   // whole bytes msb first
   // clock stands still outside frames; 48 ns period inside
   task automatic xfer(input logic [7:0] tx[$], input bit quad,
                       input int nrd, output logic [7:0] rd);
      int         per;
      logic [7:0] b;
      per = quad ? 2 : 8;
      rd = 8'h00;
      cs_n = 1'b0;
      #16;
      foreach (tx[i]) begin
         b = tx[i];
         for (int k = 0; k < per; k++) begin
            if (quad) begin
               io_in = b[7:4];
               b = b << 4;
            end else begin
               // io3 kept high: it is a live reset input in legacy frames
               io_in = {1'b1, ~last[2:1], b[7]};
               b = b << 1;
            end
            last = io_in;
            #24 spi_clk = 1'b1;
            #24 spi_clk = 1'b0;
         end
      end
      for (int k = 0; k < nrd * per; k++) begin
         idle();
         #24;
         rd = quad ? {rd[3:0], io_out} : {rd[6:0], io_out[1]};
         spi_clk = 1'b1;
         #24 spi_clk = 1'b0;
      end
      #24 cs_n = 1'b1;
      idle();
      #80;
   endtask

   // hardware reset request through io3 while deselected
   task automatic pulse_rst();
      io3_rst_n = 1'b0;
      idle();
      #200 io3_rst_n = 1'b1;
      idle();
      #80;
   endtask
endmodule

/* rtl/boot_config_store.sv */
// non-volatile copy of the interface configuration with its program timer
// assumes one start pulse per program, ignored while busy
`timescale 1ns/1ps
module boot_config_store #(
   parameter int unsigned PROGRAM_CYCLES = flash_cfg_pkg::NV_PROGRAM_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       prog_start,
   input  wire logic [7:0] prog_data,
   output logic            busy,
   output logic            done,
   output logic [7:0]      rd_data
);
   import flash_cfg_pkg::*;

   localparam int CW = $clog2(PROGRAM_CYCLES + 1);

   logic [7:0]    mem_q;
   logic [7:0]    pend_q;
   logic [CW-1:0] cnt_q;
   logic          fin_q;
   wire           take_w = prog_start & ~busy;
   wire           last_w = busy & ~fin_q & (cnt_q == '0);

   ////////////////////////////////////////////////////////////////////////
   // rst stands for power-on of a blank part; other resets leave it alone
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_q   <= BOOT_CFG_RESET;
         pend_q  <= 8'h00;
         cnt_q   <= '0;
         fin_q   <= 1'b0;
         busy    <= 1'b0;
         done    <= 1'b0;
         rd_data <= BOOT_CFG_RESET;
      end else begin
         rd_data <= mem_q;
         done    <= fin_q;
         fin_q   <= last_w;
         if (take_w) begin
            pend_q <= prog_data & BOOT_WR_MASK;
            cnt_q  <= CW'(PROGRAM_CYCLES - 1);
            busy   <= 1'b1;
         end else if (fin_q) begin
            busy <= 1'b0;
         end else if (busy & (cnt_q != '0)) begin
            cnt_q <= cnt_q - CW'(1);
         end
         if (last_w) begin
            mem_q <= pend_q;
         end
      end
   end

endmodule

/* rtl/flash_cfg_pkg.sv */
// constants, types and command codes for the interface configuration block
// assumes a 125 MHz reference clock and a serial flash style host link
package flash_cfg_pkg;

   // live and boot copies share one layout, msb first
   typedef struct packed {
      logic       io3_reset_en;
      logic [1:0] drive_strength;
      logic       reserved_hi;
      logic       quad_instr;
      logic       protect_sel;
      logic       addr_boot;
      logic       addr_live;
   } iface_cfg_s;

   // factory state of the boot copy: weakest drive, all else clear
   localparam logic [7:0] BOOT_CFG_RESET  = 8'h60;
   // writable bits of the boot copy (bits 4 and 0 carry nothing)
   localparam logic [7:0] BOOT_WR_MASK    = 8'hEE;
   // writable bits of the live copy (bit 1 read only, bit 4 reserved)
   localparam logic [7:0] LIVE_WR_MASK    = 8'hED;

   // register addresses used by the any-register commands
   localparam logic [31:0] ADDR_BOOT_CFG   = 32'h0000_0010;
   localparam logic [31:0] ADDR_LIVE_CFG   = 32'h0000_0020;
   localparam logic [31:0] ADDR_STATUS_ONE = 32'h0000_0030;
   localparam int unsigned STATUS_BUSY_BIT = 0;
   localparam int unsigned STATUS_WEL_BIT  = 1;

   // instruction codes
   localparam logic [7:0] QUAD_INSTRUCTION_ENTER_CMD   = 8'h38;
   localparam logic [7:0] QUAD_INSTRUCTION_EXIT_CMD    = 8'hF5;
   localparam logic [7:0] NONVOLATILE_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] READ_ANY_REGISTER_CMD        = 8'h65;
   localparam logic [7:0] WRITE_ANY_REGISTER_CMD       = 8'h71;
   localparam logic [7:0] ADDR_FOUR_ENTER_CMD          = 8'hB7;
   localparam logic [7:0] ADDR_FOUR_EXIT_CMD           = 8'hE9;

   // index of the last link clock edge of a byte, and of the last address byte
   localparam logic [2:0] SERIAL_LAST_EDGE = 3'h7;
   localparam logic [2:0] QUAD_LAST_EDGE   = 3'h1;
   localparam logic [2:0] ADDR_LAST_THREE  = 3'h2;
   localparam logic [2:0] ADDR_LAST_FOUR   = 3'h3;

   // timing
   localparam int unsigned REF_CLK_MHZ                = 125;
   localparam int unsigned NV_PROGRAM_TIME_US         = 200;
   localparam int unsigned NV_PROGRAM_CYCLES          =
      NV_PROGRAM_TIME_US * REF_CLK_MHZ;
   localparam int unsigned QUAD_ENTER_SWITCH_TIME_NS  = 40;
   localparam int unsigned QUAD_EXIT_SWITCH_TIME_NS   = 40;
   localparam int unsigned QUAD_ENTER_SWITCH_CYCLES   =
      (QUAD_ENTER_SWITCH_TIME_NS * REF_CLK_MHZ) / 1000;
   localparam int unsigned QUAD_EXIT_SWITCH_CYCLES    =
      (QUAD_EXIT_SWITCH_TIME_NS * REF_CLK_MHZ) / 1000;

   typedef enum logic [1:0] {
      PH_CMD  = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b10,
      PH_SKIP = 2'b11
   } phase_e;

endpackage

/* rtl/iface_config_core.sv */
// interface configuration registers of a serial flash with its link front
// assumes spi_clk idles outside frames and io pins are combined outside
`timescale 1ns/1ps
module iface_config_core #(
   parameter int unsigned PROGRAM_CYCLES = flash_cfg_pkg::NV_PROGRAM_CYCLES
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      spi_clk,
   input  wire logic                      cs_n,
   input  wire logic [3:0]                io_in,
   output logic [3:0]                     io_out,
   output logic [3:0]                     io_oe_n,
   input  wire logic                      quad_data_enable,
   input  wire logic                      sw_reset_req,
   output flash_cfg_pkg::iface_cfg_s      live_cfg,
   output logic                           quad_width_active,
   output logic                           nv_busy
);
   import flash_cfg_pkg::*;

   localparam int SW_IN  = QUAD_ENTER_SWITCH_CYCLES;
   localparam int SW_OUT = QUAD_EXIT_SWITCH_CYCLES;

   ////////////////////////////////////////////////////////////////////////
   // link domain: raw capture, one toggle per rising edge
   logic [7:0] ser_q;
   logic [7:0] nib_q;
   logic       tgl_q;

   always_ff @(posedge spi_clk or posedge rst) begin
      if (rst) begin
         ser_q <= 8'h00;
         nib_q <= 8'h00;
         tgl_q <= 1'b0;
      end else begin
         ser_q <= {ser_q[6:0], io_in[0]};
         nib_q <= {nib_q[3:0], io_in};
         tgl_q <= ~tgl_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crossings into ref_clk; captured words hold a full link period
   logic       cs_s1, cs_s2, cs_s3;
   logic       tg_s1, tg_s2, tg_s3;
   logic       io3_s1, io3_s2;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {cs_s1, cs_s2, cs_s3}    <= 3'h7;
         {tg_s1, tg_s2, tg_s3}    <= 3'h0;
         {io3_s1, io3_s2}         <= 2'h3;
      end else begin
         {cs_s1, cs_s2, cs_s3}    <= {cs_n, cs_s1, cs_s2};
         {tg_s1, tg_s2, tg_s3}    <= {tgl_q, tg_s1, tg_s2};
         {io3_s1, io3_s2}         <= {io_in[3], io3_s1};
      end
   end

   wire frame_start = cs_s3 & ~cs_s2;
   wire frame_end   = ~cs_s3 & cs_s2;
   wire edge_seen   = (tg_s2 ^ tg_s3) & ~cs_s2;

   ////////////////////////////////////////////////////////////////////////
   // frame decode
   phase_e      phase_q, phase_d;
   iface_cfg_s  live_q, live_d;
   logic        frame_qpi_q;
   logic [2:0]  edge_cnt_q;
   logic [2:0]  byte_cnt_q;
   logic [7:0]  cmd_q;
   logic [31:0] addr_q;
   logic [7:0]  wdata_q;
   logic        wdata_ok_q;
   logic [7:0]  out_sh_q, out_sh_d;
   logic        out_act_q, out_act_d;
   logic        wel_q;
   logic        quad_act_q;
   logic [7:0]  boot_rd;
   logic        busy_w;
   logic        done_w;

   wire [2:0]  last_edge  = frame_qpi_q ? QUAD_LAST_EDGE : SERIAL_LAST_EDGE;
   wire        byte_done  = edge_seen & (edge_cnt_q == last_edge);
   wire [7:0]  byte_w     = frame_qpi_q ? nib_q : ser_q;
   // any-register commands follow the live address length
   // four address bytes once four-byte mode is live
   wire [2:0]  addr_last  = live_q.addr_live ? ADDR_LAST_FOUR
                                             : ADDR_LAST_THREE;
   wire [31:0] addr_next  = {addr_q[23:0], byte_w};
   wire        is_rd      = (cmd_q == READ_ANY_REGISTER_CMD);
   wire        is_wr      = (cmd_q == WRITE_ANY_REGISTER_CMD);
   wire        addr_fin   = byte_done & (phase_q == PH_ADDR) &
                            (byte_cnt_q == addr_last);
   wire [31:0] sel_addr   = (phase_q == PH_ADDR) ? addr_next : addr_q;
   wire [7:0]  status_w   = {6'h00, wel_q, busy_w};

   // busy visible in status bit 0
   wire [7:0]  rd_val_w   =
      (sel_addr == ADDR_BOOT_CFG)   ? boot_rd :
      (sel_addr == ADDR_LIVE_CFG)   ? live_q  :
      (sel_addr == ADDR_STATUS_ONE) ? status_w : 8'h00;
   wire        out_load   = is_rd & byte_done &
                            (addr_fin | (phase_q == PH_DATA));

   always_comb begin
      phase_d = phase_q;
      if (frame_start) begin
         phase_d = PH_CMD;
      end else if (byte_done) begin
         case (phase_q)
            PH_CMD: begin
               phase_d = ((byte_w == READ_ANY_REGISTER_CMD) |
                          (byte_w == WRITE_ANY_REGISTER_CMD)) ?
                         PH_ADDR : PH_SKIP;
            end
            PH_ADDR: begin
               phase_d = addr_fin ? PH_DATA : PH_ADDR;
            end
            PH_DATA: phase_d = PH_DATA;
            PH_SKIP: phase_d = PH_SKIP;
            default: phase_d = PH_SKIP;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_q     <= PH_CMD;
         frame_qpi_q <= 1'b0;
         edge_cnt_q  <= 3'h0;
         byte_cnt_q  <= 3'h0;
         cmd_q       <= 8'h00;
         addr_q      <= 32'h0000_0000;
         wdata_q     <= 8'h00;
         wdata_ok_q  <= 1'b0;
      end else if (frame_start) begin
         phase_q     <= phase_d;
         // width taken from the live copy only
         frame_qpi_q <= live_q.quad_instr;
         edge_cnt_q  <= 3'h0;
         byte_cnt_q  <= 3'h0;
         cmd_q       <= 8'h00;
         addr_q      <= 32'h0000_0000;
         wdata_ok_q  <= 1'b0;
      end else if (edge_seen) begin
         phase_q    <= phase_d;
         edge_cnt_q <= byte_done ? 3'h0 : edge_cnt_q + 3'h1;
         if (byte_done & (phase_q == PH_CMD)) begin
            cmd_q <= byte_w;
         end
         if (byte_done & (phase_q == PH_ADDR)) begin
            addr_q     <= addr_next;
            byte_cnt_q <= byte_cnt_q + 3'h1;
         end
         if (byte_done & (phase_q == PH_DATA) & is_wr & ~wdata_ok_q) begin
            wdata_q    <= byte_w;
            wdata_ok_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data out; changes a few ref cycles after each rising link edge
   always_comb begin
      out_sh_d  = out_sh_q;
      out_act_d = out_act_q;
      if (frame_start | frame_end) begin
         out_act_d = 1'b0;
      end else if (out_load) begin
         out_sh_d  = rd_val_w;
         out_act_d = 1'b1;
      end else if (edge_seen & out_act_q) begin
         out_sh_d = frame_qpi_q ? {out_sh_q[3:0], 4'h0}
                                : {out_sh_q[6:0], 1'b0};
      end
   end

   // quad answer on all four lanes
   wire [3:0] io_out_d  = ~out_act_d ? 4'h0 :
                          frame_qpi_q ? out_sh_d[7:4]
                                      : {2'b00, out_sh_d[7], 1'b0};
   wire [3:0] io_oe_n_d = ~out_act_d ? 4'hF :
                          frame_qpi_q ? 4'h0 : 4'hD;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_sh_q  <= 8'h00;
         out_act_q <= 1'b0;
         io_out    <= 4'h0;
         io_oe_n   <= 4'hF;
      end else begin
         out_sh_q  <= out_sh_d;
         out_act_q <= out_act_d;
         io_out    <= io_out_d;
         io_oe_n   <= io_oe_n_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // commands act when the frame closes, so the next frame sees them
   wire cmd_done  = frame_end & (phase_q != PH_CMD);
   wire cmd_enter = cmd_done & (cmd_q == QUAD_INSTRUCTION_ENTER_CMD);
   wire cmd_exit  = cmd_done & (cmd_q == QUAD_INSTRUCTION_EXIT_CMD);
   wire cmd_wen   = cmd_done & (cmd_q == NONVOLATILE_WRITE_ENABLE_CMD);
   wire cmd_a4on  = cmd_done & (cmd_q == ADDR_FOUR_ENTER_CMD);
   wire cmd_a4off = cmd_done & (cmd_q == ADDR_FOUR_EXIT_CMD);
   wire wr_ok     = frame_end & is_wr & wdata_ok_q & ~busy_w;
   // boot write only after write enable
   wire prog_go   = wr_ok & wel_q & (addr_q == ADDR_BOOT_CFG);
   wire live_wr   = wr_ok & (addr_q == ADDR_LIVE_CFG);
   // io3 reset when enabled and chip select high or quad unused
   wire io3_rst   = live_q.io3_reset_en & ~io3_s2 &
                    (cs_s2 | ~quad_act_q);
   wire reload    = sw_reset_req | io3_rst;
   iface_cfg_s boot_w;
   iface_cfg_s boot_live_w;

   assign boot_w = iface_cfg_s'(boot_rd);

   // live copy loaded from boot copy, address length mirrored
   always_comb begin
      boot_live_w             = boot_w;
      boot_live_w.reserved_hi = 1'b0;
      boot_live_w.addr_live   = boot_w.addr_boot;
   end

   always_comb begin
      live_d = live_q;
      if (reload) begin
         live_d = boot_live_w;
      end else begin
         // live address bit follows a boot copy update
         if (done_w) begin
            live_d.addr_boot = boot_w.addr_boot;
            live_d.addr_live = boot_w.addr_boot;
         end
         // live register write may set quad mode
         if (live_wr) begin
            live_d = iface_cfg_s'((wdata_q & LIVE_WR_MASK) |
                                  (live_d & ~LIVE_WR_MASK));
         end
         if (cmd_enter) begin
            live_d.quad_instr = 1'b1;
         end
         if (cmd_exit) begin
            live_d.quad_instr = 1'b0;
         end
         if (cmd_a4on) begin
            live_d.addr_live = 1'b1;
         end
         if (cmd_a4off) begin
            live_d.addr_live = 1'b0;
         end
      end
   end

   // switch lands one cycle after the frame closes
   // live copy fields drive the live outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         live_q     <= iface_cfg_s'(BOOT_CFG_RESET);
         quad_act_q <= 1'b0;
         wel_q      <= 1'b0;
      end else begin
         live_q     <= live_d;
         // quad width follows the quad instruction bit or quad_data_enable
         quad_act_q <= quad_data_enable | live_d.quad_instr;
         wel_q      <= cmd_wen ? 1'b1 :
                       (done_w | reload) ? 1'b0 : wel_q;
      end
   end

   assign live_cfg          = live_q;
   assign quad_width_active = quad_act_q;
   assign nv_busy           = busy_w;

   boot_config_store #(
      .PROGRAM_CYCLES (PROGRAM_CYCLES)
   ) u_store (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .prog_start (prog_go),
      .prog_data  (wdata_q),
      .busy       (busy_w),
      .done       (done_w),
      .rd_data    (boot_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_prog_run;
      busy_w [*3];
   endsequence

   a_prog_busy_hold: assert property (prog_go |=> s_prog_run)
      else $error("busy not held after program start");
   a_prog_needs_wel: assert property (
      (wr_ok & ~wel_q & (addr_q == ADDR_BOOT_CFG)) |=> ~busy_w)
      else $error("boot program without write enable");
   a_quad_enter_time: assert property (
      (cmd_enter & ~reload) |-> ##[1:SW_IN] live_q.quad_instr)
      else $error("quad enter not complete in time");
   a_quad_exit_time: assert property (
      (cmd_exit & ~reload) |-> ##[1:SW_OUT] ~live_q.quad_instr)
      else $error("quad exit not complete in time");
   a_reset_reload: assert property (
      reload |=> (live_q == $past(boot_live_w)))
      else $error("live copy not reloaded from boot copy");
   a_reserved_zero: assert property (
      ~live_q.reserved_hi & ~boot_rd[0] & ~boot_rd[4])
      else $error("reserved bit set");
   a_addr_mirror: assert property (
      (done_w & ~reload) |=> (live_q.addr_live == live_q.addr_boot))
      else $error("live address bit not updated");
   a_io3_quiet: assert property (
      (~cs_s2 & quad_act_q) |-> ~io3_rst)
      else $error("io3 reset while io3 carries data");
   a_serial_width: assert property (
      (byte_done & ~frame_qpi_q) |-> (edge_cnt_q == 3'h7))
      else $error("serial byte not eight edges");
   a_quad_lanes: assert property (
      (out_act_q & frame_qpi_q) |=> (io_oe_n == 4'h0) || ~out_act_q)
      else $error("quad answer not on four lanes");
   a_serial_lane: assert property (
      (out_act_q & ~frame_qpi_q) |=> (io_oe_n == 4'hD) || ~out_act_q)
      else $error("legacy answer not on io1 alone");
   a_quad_active: assert property (
      live_q.quad_instr |-> quad_act_q)
      else $error("quad width not active with quad instructions");

endmodule
